// ==== vcc_top.sv ====
// vcc_top: video stream core with optional memory-mapped control port
// assumes: stream partners run on core_clk; the bus master runs on s_axi_aclk
`timescale 1ns/1ps
module vcc_top
  import vcc_pkg::*;
#(
  parameter bit HAS_CTRL = 1'b1
) (
  input  wire logic              core_clk,             // video clock
  input  wire logic              srst,                 // video reset, active high
  input  wire logic              vid_clk_en,           // video clock enable
  input  wire logic [VID_W-1:0]  s_axis_video_tdata,   // input pixel
  input  wire logic              s_axis_video_tvalid,  // input valid
  output      logic              s_axis_video_tready,  // input ready
  input  wire logic              s_axis_video_tuser,   // input start of frame
  input  wire logic              s_axis_video_tlast,   // input end_of_line_flag
  output      logic [VID_W-1:0]  m_axis_video_tdata,   // output pixel
  output      logic              m_axis_video_tvalid,  // output valid
  input  wire logic              m_axis_video_tready,  // output ready
  output      logic              m_axis_video_tuser,   // output start of frame
  output      logic              m_axis_video_tlast,   // output end_of_line_flag
  input  wire logic              s_axi_aclk,           // control clock
  input  wire logic              s_axi_aclken,         // control clock enable
  input  wire logic              s_axi_aresetn,        // control reset, active low
  input  wire logic              s_axi_awvalid,        // write address valid
  output      logic              s_axi_awready,        // write address ready
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,         // write address
  input  wire logic              s_axi_wvalid,         // write data valid
  output      logic              s_axi_wready,         // write data ready
  input  wire logic [AXI_DW-1:0] s_axi_wdata,          // write data
  output      logic [1:0]        s_axi_bresp,          // write response
  output      logic              s_axi_bvalid,         // write response valid
  input  wire logic              s_axi_bready,         // write response ready
  input  wire logic              s_axi_arvalid,        // read address valid
  output      logic              s_axi_arready,        // read address ready
  input  wire logic [AXI_AW-1:0] s_axi_araddr,         // read address
  output      logic              s_axi_rvalid,         // read data valid
  input  wire logic              s_axi_rready,         // read data ready
  output      logic [AXI_DW-1:0] s_axi_rdata,          // read data
  output      logic [1:0]        s_axi_rresp           // read response
);

  // ----------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
    logic              aw_have;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_have;
    logic [AXI_DW-1:0] w_data;
    logic              run;
    logic [DIM_W-1:0]  pix;
    logic [DIM_W-1:0]  lin;
    logic              dirty;
    logic [STS_W-1:0]  sts;
  } vcc_axi_s;

  typedef struct packed {
    logic [CFG_W-1:0]  cfg;
    logic [DIM_W-1:0]  pix;
    logic [DIM_W-1:0]  lin;
    logic [FRM_W-1:0]  frames;
    logic [ERR_W-1:0]  err;
    logic              ovalid;
    logic [VID_W-1:0]  odata;
    logic              olast;
    logic              ouser;
    logic              iready;
  } vcc_core_s;

  vcc_axi_s  a_q, a_d;
  vcc_core_s c_q, c_d;

  logic             ctl_rst_core;
  logic             core_rst;
  logic [CFG_W-1:0] cfg_core;
  logic [STS_W-1:0] sts_axi;
  logic [STS_W-1:0] sts_core;
  logic             cfg_busy;
  logic             cfg_send;

  function automatic vcc_sel_e reg_sel(input logic [AXI_AW-1:0] addr);
    logic [AXI_AW-1:0] word;
    word = {addr[AXI_AW-1:2], 2'h0};
    if (word == OFS_CTRL) begin
      return SEL_CTRL;
    end else if (word == OFS_STATE) begin
      return SEL_STATE;
    end else if (word == OFS_SIZE) begin
      return SEL_SIZE;
    end
    return SEL_NONE;
  endfunction

  // ----------------------------------------------------------------
  // build option: crossings only exist with the control port
  // ----------------------------------------------------------------
  assign core_rst = srst | ctl_rst_core;
  assign cfg_send = a_q.dirty & s_axi_aclken;
  assign sts_core = {c_q.frames, {(STS_W - FRM_W - ERR_W){1'b0}}, c_q.err};

  generate
    if (HAS_CTRL) begin : g_ctrl
      // relies on the master holding reset long enough for both flops
      vcc_rst_sync u_rst_sync (
        .clk      (core_clk),
        .srst     (srst),
        .rst_in_n (s_axi_aresetn),
        .rst_out  (ctl_rst_core)
      );

      vcc_word_sync #(.W(CFG_W), .RST_VAL(CFG_RST)) u_cfg_sync (
        .src_clk  (s_axi_aclk),
        .src_rst  (~s_axi_aresetn),
        .src_send (cfg_send),
        .src_data ({a_q.run, a_q.lin, a_q.pix}),
        .src_busy (cfg_busy),
        .dst_clk  (core_clk),
        .dst_rst  (core_rst),
        .dst_data (cfg_core)
      );

      // status refreshes continuously; a reader sees a value a few cycles old
      vcc_word_sync #(.W(STS_W), .RST_VAL('0)) u_sts_sync (
        .src_clk  (core_clk),
        .src_rst  (core_rst),
        .src_send (1'b1),
        .src_data (sts_core),
        .src_busy (),
        .dst_clk  (s_axi_aclk),
        .dst_rst  (~s_axi_aresetn),
        .dst_data (sts_axi)
      );
    end else begin : g_fixed
      assign ctl_rst_core = 1'b0;
      assign cfg_core     = CFG_FIX;
      assign cfg_busy     = 1'b0;
      assign sts_axi      = '0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // control port, control clock domain
  // ----------------------------------------------------------------
  always_comb begin
    a_d = a_q;
    if (s_axi_aclken) begin
      a_d.sts = sts_axi;
      if (a_q.dirty && !cfg_busy) begin
        a_d.dirty = 1'b0;
      end
      if (s_axi_awvalid && a_q.awready) begin
        a_d.aw_have = 1'b1;
        a_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && a_q.wready) begin
        a_d.w_have = 1'b1;
        a_d.w_data = s_axi_wdata;
      end
      if (a_q.bvalid && s_axi_bready) begin
        a_d.bvalid = 1'b0;
      end
      if (a_q.aw_have && a_q.w_have && !a_q.bvalid) begin
        a_d.aw_have = 1'b0;
        a_d.w_have  = 1'b0;
        a_d.bvalid  = 1'b1;
        a_d.bresp   = RESP_OKAY;
        case (reg_sel(a_q.aw_addr))
          SEL_CTRL: begin
            a_d.run   = a_q.w_data[CTRL_RUN_BIT];
            a_d.dirty = 1'b1;
          end
          SEL_SIZE: begin
            a_d.pix   = a_q.w_data[SIZE_PIX_LSB +: DIM_W];
            a_d.lin   = a_q.w_data[SIZE_LIN_LSB +: DIM_W];
            a_d.dirty = 1'b1;
          end
          SEL_STATE: begin
            a_d.bresp = RESP_OKAY;
          end
          default: begin
            a_d.bresp = RESP_SLVERR;
          end
        endcase
      end
      a_d.awready = !a_d.aw_have && !a_d.bvalid;
      a_d.wready  = !a_d.w_have && !a_d.bvalid;
      if (a_q.rvalid && s_axi_rready) begin
        a_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && a_q.arready) begin
        a_d.rvalid = 1'b1;
        a_d.rresp  = RESP_OKAY;
        a_d.rdata  = '0;
        case (reg_sel(s_axi_araddr))
          SEL_CTRL: begin
            a_d.rdata[CTRL_RUN_BIT] = a_q.run;
          end
          SEL_SIZE: begin
            a_d.rdata[SIZE_PIX_LSB +: DIM_W] = a_q.pix;
            a_d.rdata[SIZE_LIN_LSB +: DIM_W] = a_q.lin;
          end
          SEL_STATE: begin
            a_d.rdata[STS_W-1:0] = a_q.sts;
          end
          default: begin
            a_d.rresp = RESP_SLVERR;
          end
        endcase
      end
      a_d.arready = !a_d.rvalid;
    end
  end

  always_ff @(posedge s_axi_aclk) begin
    if (!s_axi_aresetn || !HAS_CTRL) begin
      a_q     <= '0;
      a_q.run <= RUN_RST;
      a_q.pix <= FIX_PIX;
      a_q.lin <= FIX_LIN;
    end else begin
      a_q <= a_d;
    end
  end

  // ----------------------------------------------------------------
  // video path, video clock domain
  // ----------------------------------------------------------------
  // one output register and a registered ready: half rate, no skid buffer
  always_comb begin
    logic [DIM_W-1:0] pos_pix;
    logic [DIM_W-1:0] pos_lin;
    logic             last_px;
    logic             eof;
    pos_pix = '0;
    pos_lin = '0;
    last_px = 1'b0;
    eof     = 1'b0;
    c_d     = c_q;
    if (vid_clk_en) begin
      c_d.cfg[CFG_RUN_BIT] = cfg_core[CFG_RUN_BIT];
      if (c_q.pix == '0 && c_q.lin == '0 && !c_q.ovalid) begin
        c_d.cfg = cfg_core;
      end
      if (c_q.ovalid && m_axis_video_tready) begin
        c_d.ovalid = 1'b0;
      end
      if (s_axis_video_tvalid && c_q.iready) begin
        pos_pix    = s_axis_video_tuser ? '0 : c_q.pix;
        pos_lin    = s_axis_video_tuser ? '0 : c_q.lin;
        last_px    = pos_pix == c_q.cfg[CFG_PIX_LSB +: DIM_W] - DIM_ONE;
        eof        = last_px && (pos_lin == c_q.cfg[CFG_LIN_LSB +: DIM_W] - DIM_ONE);
        c_d.ovalid = 1'b1;
        c_d.odata  = s_axis_video_tdata;
        c_d.olast  = last_px;
        c_d.ouser  = pos_pix == '0 && pos_lin == '0;
        c_d.err[ERR_LST_EARLY] = c_q.err[ERR_LST_EARLY] | (s_axis_video_tlast & ~last_px);
        c_d.err[ERR_LST_LATE]  = c_q.err[ERR_LST_LATE] | (~s_axis_video_tlast & last_px);
        c_d.err[ERR_SOF_EARLY] = c_q.err[ERR_SOF_EARLY] |
                                 (s_axis_video_tuser & (c_q.pix != '0 || c_q.lin != '0));
        c_d.pix = last_px ? '0 : pos_pix + DIM_ONE;
        c_d.lin = eof ? '0 : (last_px ? pos_lin + DIM_ONE : pos_lin);
        if (eof) begin
          c_d.frames = c_q.frames + 8'h01;
        end
      end
      c_d.iready = !c_d.ovalid && c_d.cfg[CFG_RUN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (core_rst) begin
      c_q     <= '0;
      c_q.cfg <= HAS_CTRL ? CFG_RST : CFG_FIX;
    end else begin
      c_q <= c_d;
    end
  end

  assign s_axis_video_tready = c_q.iready;
  assign m_axis_video_tvalid = c_q.ovalid;
  assign m_axis_video_tdata  = c_q.odata;
  assign m_axis_video_tlast  = c_q.olast;
  assign m_axis_video_tuser  = c_q.ouser;
  assign s_axi_awready       = a_q.awready;
  assign s_axi_wready        = a_q.wready;
  assign s_axi_bvalid        = a_q.bvalid;
  assign s_axi_bresp         = a_q.bresp;
  assign s_axi_arready       = a_q.arready;
  assign s_axi_rvalid        = a_q.rvalid;
  assign s_axi_rdata         = a_q.rdata;
  assign s_axi_rresp         = a_q.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic             m_xfer;
  logic [DIM_W-1:0] beat_h;

  assign m_xfer = m_axis_video_tvalid & m_axis_video_tready & vid_clk_en;

  always_ff @(posedge core_clk) begin
    if (core_rst) begin
      beat_h <= '0;
    end else if (m_xfer) begin
      beat_h <= m_axis_video_tlast ? '0 : beat_h + DIM_ONE;
    end
  end

  chk_last_spacing: assert property (@(posedge core_clk) disable iff (core_rst)
    m_xfer && m_axis_video_tlast |-> beat_h == c_q.cfg[CFG_PIX_LSB +: DIM_W] - DIM_ONE)
    else $error("end of line flag off the last pixel");

  chk_sof_first: assert property (@(posedge core_clk) disable iff (core_rst)
    m_xfer && m_axis_video_tuser |-> beat_h == '0)
    else $error("start of frame flag off a line start");

  chk_in_gate: assert property (@(posedge core_clk) disable iff (core_rst)
    !(s_axis_video_tvalid && s_axis_video_tready && vid_clk_en) && !m_axis_video_tvalid
    |=> !m_axis_video_tvalid)
    else $error("output filled without an input transfer");

  chk_vid_hold: assert property (@(posedge core_clk) disable iff (core_rst)
    !vid_clk_en |=> $stable({m_axis_video_tvalid, m_axis_video_tdata, s_axis_video_tready}))
    else $error("stream moved while video clock enable low");

  generate
    if (HAS_CTRL) begin : g_chk
      sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_aclken;
      endsequence

      chk_wr_resp: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
        s_wr_both ##1 s_axi_aclken |=> s_axi_bvalid)
        else $error("write not answered");

      chk_bresp_hold: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");

      chk_rd_resp: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_aclken |=> s_axi_rvalid)
        else $error("read not answered");

      chk_rdata_hold: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
        else $error("read data changed before rready");

      chk_ctl_freeze: assert property (@(posedge s_axi_aclk) disable iff (!s_axi_aresetn)
        !s_axi_aclken |=> $stable({s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid}))
        else $error("control port moved while its enable low");

      chk_ctl_reset: assert property (@(posedge s_axi_aclk)
        !s_axi_aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
        else $error("control reset did not act");

      chk_ctl_resets_vid: assert property (@(posedge core_clk)
        ctl_rst_core |=> !m_axis_video_tvalid && !s_axis_video_tready)
        else $error("control reset did not clear the stream");
    end
  endgenerate
endmodule

// ==== vcc_pkg.sv ====
// vcc_pkg: constants shared by the video core control port and its crossings
// assumes: one 24-bit pixel per stream beat, control words of 32 bits
package vcc_pkg;
  localparam int unsigned       VID_W        = 24;
  localparam int unsigned       AXI_AW       = 32;
  localparam int unsigned       AXI_DW       = 32;
  localparam int unsigned       DIM_W        = 13;
  localparam int unsigned       CFG_W        = 2 * DIM_W + 1;
  localparam int unsigned       STS_W        = 16;
  localparam int unsigned       FRM_W        = 8;
  localparam int unsigned       ERR_W        = 3;
  localparam logic [1:0]        RESP_OKAY    = 2'h0;
  localparam logic [1:0]        RESP_SLVERR  = 2'h2;
  localparam logic [31:0]       OFS_CTRL     = 32'h0000_0000;
  localparam logic [31:0]       OFS_STATE    = 32'h0000_0004;
  localparam logic [31:0]       OFS_SIZE     = 32'h0000_0020;
  localparam int unsigned       CTRL_RUN_BIT = 0;
  localparam int unsigned       SIZE_PIX_LSB = 0;
  localparam int unsigned       SIZE_LIN_LSB = 16;
  localparam int unsigned       CFG_PIX_LSB  = 0;
  localparam int unsigned       CFG_LIN_LSB  = DIM_W;
  localparam int unsigned       CFG_RUN_BIT  = 2 * DIM_W;
  localparam int unsigned       ERR_LST_EARLY = 0;
  localparam int unsigned       ERR_LST_LATE  = 1;
  localparam int unsigned       ERR_SOF_EARLY = 2;
  localparam logic              RUN_RST      = 1'h0;
  localparam logic [DIM_W-1:0]  FIX_PIX      = 13'h0780;
  localparam logic [DIM_W-1:0]  FIX_LIN      = 13'h0438;
  localparam logic [DIM_W-1:0]  DIM_ONE      = 13'h0001;
  localparam logic [CFG_W-1:0]  CFG_RST      = {RUN_RST, FIX_LIN, FIX_PIX};
  localparam logic [CFG_W-1:0]  CFG_FIX      = {1'h1, FIX_LIN, FIX_PIX};
  typedef enum logic [1:0] {SEL_CTRL, SEL_STATE, SEL_SIZE, SEL_NONE} vcc_sel_e;
endpackage

// ==== vcc_rst_sync.sv ====
// vcc_rst_sync: brings the control port reset into the video clock domain
// assumes: the incoming reset is held long enough to be seen by two flops
`timescale 1ns/1ps
module vcc_rst_sync
  import vcc_pkg::*;
(
  input  wire logic clk,       // video clock
  input  wire logic srst,      // video reset, active high
  input  wire logic rst_in_n,  // control reset from the other domain, active low
  output      logic rst_out    // control reset seen in this domain, active high
);
  typedef struct packed {
    logic s1;
    logic s2;
  } vcc_rsync_s;

  vcc_rsync_s q, d;

  always_comb begin
    d    = q;
    d.s1 = ~rst_in_n;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign rst_out = q.s2;
endmodule

// ==== vcc_word_sync.sv ====
// vcc_word_sync: carries a word between two clocks by a toggle handshake
// assumes: src_data is sampled only when src_send is high and src_busy is low
`timescale 1ns/1ps
module vcc_word_sync
  import vcc_pkg::*;
#(
  parameter int unsigned  W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         src_clk,   // sending clock
  input  wire logic         src_rst,   // sending reset, active high
  input  wire logic         src_send,  // offer src_data
  input  wire logic [W-1:0] src_data,  // word to carry
  output      logic         src_busy,  // a word is in flight
  input  wire logic         dst_clk,   // receiving clock
  input  wire logic         dst_rst,   // receiving reset, active high
  output      logic [W-1:0] dst_data   // last word delivered
);
  typedef struct packed {
    logic         req;
    logic         ack_s1;
    logic         ack_s2;
    logic [W-1:0] data;
  } vcc_src_s;

  typedef struct packed {
    logic         req_s1;
    logic         req_s2;
    logic         seen;
    logic [W-1:0] data;
  } vcc_dst_s;

  vcc_src_s s_q, s_d;
  vcc_dst_s r_q, r_d;

  // held data stays still until the far side acknowledges, so no bit can tear
  always_comb begin
    s_d        = s_q;
    s_d.ack_s1 = r_q.seen;
    s_d.ack_s2 = s_q.ack_s1;
    if (src_send && (s_q.req == s_q.ack_s2)) begin
      s_d.req  = ~s_q.req;
      s_d.data = src_data;
    end
  end

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    r_d        = r_q;
    r_d.req_s1 = s_q.req;
    r_d.req_s2 = r_q.req_s1;
    if (r_q.req_s2 != r_q.seen) begin
      r_d.seen = r_q.req_s2;
      r_d.data = s_q.data;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      r_q <= '{req_s1: 1'b0, req_s2: 1'b0, seen: 1'b0, data: RST_VAL};
    end else begin
      r_q <= r_d;
    end
  end

  assign src_busy = s_q.req != s_q.ack_s2;
  assign dst_data = r_q.data;
endmodule

// ==== vcc_axi_master.sv ====
// vcc_axi_master: behavioural control-bus master, one transfer at a time
// assumes: aclk runs free; en mirrors the control clock enable
`timescale 1ns/1ps
module vcc_axi_master (
  input  wire logic        aclk,     // control clock
  input  wire logic        en,       // control clock enable
  output      logic        awvalid,  // write address valid
  input  wire logic        awready,  // write address ready
  output      logic [31:0] awaddr,   // write address
  output      logic        wvalid,   // write data valid
  input  wire logic        wready,   // write data ready
  output      logic [31:0] wdata,    // write data
  input  wire logic [1:0]  bresp,    // write response
  input  wire logic        bvalid,   // write response valid
  output      logic        bready,   // write response ready
  output      logic        arvalid,  // read address valid
  input  wire logic        arready,  // read address ready
  output      logic [31:0] araddr,   // read address
  input  wire logic        rvalid,   // read data valid
  output      logic        rready,   // read data ready
  input  wire logic [31:0] rdata,    // read data
  input  wire logic [1:0]  rresp     // read response
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
  end
  // released lines show the inverse so a stale value never passes for a fresh one
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input int stall, output logic [1:0] r);
    @(negedge aclk);
    {awaddr, wdata, awvalid, wvalid} = {a, d, 2'h3};
    do @(posedge aclk); while (!(awready && wready && en));
    @(negedge aclk);
    {awaddr, wdata, awvalid, wvalid} = {~a, ~d, 2'h0};
    repeat (stall) @(negedge aclk);
    bready = 1'b1;
    do @(posedge aclk); while (!(bvalid && en));
    r = bresp;
    @(negedge aclk);
    bready = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input int stall, output logic [31:0] d, output logic [1:0] r);
    @(negedge aclk);
    {araddr, arvalid} = {a, 1'h1};
    do @(posedge aclk); while (!(arready && en));
    @(negedge aclk);
    {araddr, arvalid} = {~a, 1'h0};
    repeat (stall) @(negedge aclk);
    rready = 1'b1;
    do @(posedge aclk); while (!(rvalid && en));
    {d, r} = {rdata, rresp};
    @(negedge aclk);
    rready = 1'b0;
  endtask
endmodule

// ==== vcc_top_tb.sv ====
// vcc_top_tb: self-checking bench for the video core control port
// assumes: pixels pass unchanged; flags follow the programmed frame size
`timescale 1ns/1ps
module vcc_top_tb;
  import vcc_pkg::*;
  localparam int PIX = 4;
  localparam int LIN = 3;
  logic             core_clk, srst, vid_clk_en, aclk, aclken, aresetn;
  logic [VID_W-1:0] s_data, m_data;
  logic             s_valid, s_ready, s_user, s_last, m_valid, m_ready, m_user, m_last;
  logic             awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [31:0]      awa, wd, ara, rdat, rd;
  logic [1:0]       bresp, rresp, resp;
  logic [VID_W+1:0] exp_q[$];
  int               mismatches, cmp_count, seed;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    aclk = 1'b0;
    #13;
    forever #80 aclk = ~aclk;
  end
  vcc_top #(.HAS_CTRL(1'b1)) i_dut (.core_clk(core_clk), .srst(srst), .vid_clk_en(vid_clk_en),
    .s_axis_video_tdata(s_data), .s_axis_video_tvalid(s_valid), .s_axis_video_tready(s_ready),
    .s_axis_video_tuser(s_user), .s_axis_video_tlast(s_last), .m_axis_video_tdata(m_data),
    .m_axis_video_tvalid(m_valid), .m_axis_video_tready(m_ready), .m_axis_video_tuser(m_user),
    .m_axis_video_tlast(m_last), .s_axi_aclk(aclk), .s_axi_aclken(aclken), .s_axi_aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp));
  vcc_axi_master i_mst (.aclk(aclk), .en(aclken), .awvalid(awv), .awready(awr), .awaddr(awa),
    .wvalid(wv), .wready(wr), .wdata(wd), .bresp(bresp), .bvalid(bv), .bready(br), .arvalid(arv),
    .arready(arr), .araddr(ara), .rvalid(rv), .rready(rr), .rdata(rdat), .rresp(rresp));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ctrl_reset;
    @(negedge aclk);
    aresetn = 1'b0;
    repeat (34) @(negedge aclk);
    aresetn = 1'b1;
    @(negedge aclk);
  endtask
  // ---------------------------------------------------------------
  // stream stimulus; each accepted beat leaves a note for the monitor
  // ---------------------------------------------------------------
  task automatic send_frames(input int nf);
    for (int i = 0; i < nf * PIX * LIN; i++) begin
      @(negedge core_clk);
      s_data = VID_W'($random(seed));
      {s_user, s_last, s_valid} = {i % (PIX * LIN) == 0, i % PIX == PIX - 1, 1'b1};
      do @(posedge core_clk); while (!(s_ready && vid_clk_en));
      exp_q.push_back({s_user, s_last, s_data});
      @(negedge core_clk);
      {s_valid, s_data, s_user, s_last} = {1'b0, ~s_data, ~s_user, ~s_last};
    end
  endtask
  always @(posedge core_clk) begin
    if (!srst && vid_clk_en && m_valid && m_ready) begin
      if (exp_q.size() == 0) chk("spare beat", 32'h1, 32'h0);
      else chk("out beat", {6'h0, m_user, m_last, m_data}, {6'h0, exp_q.pop_front()});
    end
  end
  // random stalls on the output side and random gaps in the video enable
  initial forever begin
    @(negedge core_clk);
    m_ready = ($random(seed) % 4) != 0;
    vid_clk_en = ($random(seed) % 5) != 0;
  end
  // random gaps in the control clock enable, reset included
  initial forever begin
    @(negedge aclk);
    aclken = ($random(seed) % 4) != 0;
  end
  initial begin
    #300000;
    mismatches++;
    wrap_up();
  end
  initial begin
    seed = 4510;
    {srst, aclken, aresetn, vid_clk_en, m_ready} = 5'h1A;
    {s_valid, s_user, s_last, s_data} = '0;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    ctrl_reset();
    i_mst.rd(OFS_SIZE, 0, rd, resp);
    chk("size reset", rd, {3'h0, FIX_LIN, 3'h0, FIX_PIX});
    chk("size rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    i_mst.rd(32'h0000_0010, 2, rd, resp);
    chk("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    i_mst.wr(32'h0000_0044, 32'hFFFF_FFFF, 0, resp);
    chk("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    i_mst.wr(OFS_SIZE, (LIN << 16) | PIX, 3, resp);
    chk("size bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    i_mst.wr(OFS_CTRL, 32'h1, 1, resp);
    i_mst.rd(OFS_SIZE, 1, rd, resp);
    chk("size back", rd, (LIN << 16) | PIX);
    repeat (4) @(negedge aclk);
    send_frames(2);
    for (int k = 0; k < 300 && exp_q.size() != 0; k++) @(negedge core_clk);
    chk("beats left", exp_q.size(), 32'h0);
    // status crosses with a lag of several control cycles
    repeat (16) @(negedge aclk);
    i_mst.rd(OFS_STATE, 0, rd, resp);
    chk("error bits", {29'h0, rd[2:0]}, 32'h0);
    chk("frame count", {24'h0, rd[15:8]}, 32'h2);
    ctrl_reset();
    repeat (3) @(negedge aclk);
    chk("ready after reset", {31'h0, s_ready}, 32'h0);
    i_mst.rd(OFS_CTRL, 0, rd, resp);
    chk("run after reset", rd, 32'h0);
    wrap_up();
  end
endmodule
